// ==== logic/vbmi_pkg.sv ====
/*
  package for the vpw bus mux interface: register map, field positions,
  symbol times and the derived cycle counts.
  assumes a 125 MHz system clock and an apb register bus.
*/
package vbmi_pkg;
  // ------------------------------------------------------------
  // clock and symbol times
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int T_SHORT_US = 64;
  localparam int T_LONG_US = 128;
  localparam int T_SOF_US = 200;
  localparam int T_EOD_US = 200;
  localparam int T_EOF_US = 280;
  localparam int T_IFS_US = 20;
  localparam int T_IDLE_US = 300;
  localparam int T_BRK_US = 240;
  localparam int C_SHORT = T_SHORT_US * CLK_MHZ;
  localparam int C_LONG = T_LONG_US * CLK_MHZ;
  localparam int C_SOF = T_SOF_US * CLK_MHZ;
  localparam int C_EOD = T_EOD_US * CLK_MHZ;
  localparam int C_EOF = T_EOF_US * CLK_MHZ;
  localparam int C_IDLE = (T_EOF_US + T_IFS_US) * CLK_MHZ;
  localparam int C_BRK = T_BRK_US * CLK_MHZ;
  // receive decision thresholds, midway between nominal times, except bit minimum at half the short time
  localparam int C_BIT_MIN = (T_SHORT_US / 2) * CLK_MHZ;
  localparam int C_BIT_MID = ((T_SHORT_US + T_LONG_US) / 2) * CLK_MHZ;
  localparam int C_SOF_MIN = ((T_LONG_US + T_SOF_US) / 2) * CLK_MHZ;
  localparam int C_EOD_MIN = ((T_LONG_US + T_EOD_US) / 2) * CLK_MHZ;
  localparam int CNT_W = 16;

  // ------------------------------------------------------------
  // filter
  // ------------------------------------------------------------
  localparam logic [3:0] FILT_MAX = 4'hF;
  localparam logic [3:0] FILT_MIN = 4'h0;

  // ------------------------------------------------------------
  // crc
  // ------------------------------------------------------------
  localparam logic [7:0] CRC_POLY = 8'h1D;
  localparam logic [7:0] CRC_PRESET = 8'hFF;
  localparam logic [7:0] CRC_GOOD = 8'hC4;
  localparam int MAX_BYTES = 12;

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TXDATA = 8'h08;
  localparam logic [7:0] ADDR_RXDATA = 8'h0C;
  // control register fields
  localparam int CTL_FAST_RX = 0;
  localparam int CTL_TX_EOD = 1;
  // status fields, bits 0 to 4 held in state_vector_reg (write one to clear)
  localparam int ST_RX_BYTE = 0;
  localparam int ST_CRC_ERR = 1;
  localparam int ST_INV_SYM = 2;
  localparam int ST_EOF = 3;
  localparam int ST_TX_ERR = 4;
  localparam int ST_IDLE = 5;
  localparam int ST_TX_BUSY = 6;
  localparam int ST_TX_EMPTY = 7;
  localparam int ST_W = 8;

  typedef struct packed {
    logic rx_byte;
    logic crc_err;
    logic inv_sym;
    logic eof;
    logic tx_err;
  } vbmi_evt_t;

  function automatic logic [7:0] vbmi_crc_bit(input logic [7:0] crc, input logic b);
    vbmi_crc_bit = {crc[6:0], 1'b0} ^ ((crc[7] ^ b) ? CRC_POLY : 8'h00);
  endfunction
endpackage

// ==== logic/vbmi_top.sv ====
/*
  vpw bus mux interface: receive noise filter, vpw symbol decode and
  encode, crc generation and check, break and idle detection, apb slave.
  assumes raw_rx_input is synchronous to clk_i and an off-chip
  transceiver inverts nothing (high on raw pins means active bus).
*/
// Operation
// - sample raw input each edge, apply counter update one step later
// - filter counter counts up on high, down on low, bounded 0..15
// - at 15 set filtered latch, counter may only decrement
// - at 0 clear filtered latch, counter may only increment
// - filtered level only changes at the opposite end point
// - clean edge shows at filtered output after 15 to 16 periods; rx_filtered_o adds one more register, so 16 to 17
// - frame at most 12 bytes, each byte sent msb first
// - frame starts with 200 us active sof, not in crc
// - sent frame has at least one data byte then crc
// - crc polynomial x8+x4+x3+x2+1, preset all ones, serial per byte
// - append inverted remainder as crc byte, msb first
// - receive crc remainder not c4 sets crc error flag
// - 200 us passive end of data raises no flag
// - 280 us passive is end of frame, raises eof flag
// - wait 20 us more, 300 us passive total, before new sof
// - waiting for separation, early rising edge resynchronizes timing
// - never send break; break while sending is tx error and stop
// - break during reception sets invalid symbol, drops frame
// - break in fast receive mode also clears fast receive enable
// - passive beyond 300 us is idle, transmit may start at once
// - bits alternate levels, one transition, 64 or 128 us
// - first bit of every byte is passive
// - zero is passive 64 us or active 128 us
// - one is passive 128 us or active 64 us
module vbmi_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic raw_rx_input,
  output logic raw_tx_output,
  output logic rx_filtered_o
);
  // ------------------------------------------------------------
  // receive filter
  // ------------------------------------------------------------
  logic samp_reg;
  logic [3:0] filt_reg;
  logic filt_q_reg;
  logic prev_filt_reg;
  logic [3:0] filt_next;
  wire rise = filt_q_reg & ~prev_filt_reg;
  wire fall = ~filt_q_reg & prev_filt_reg;
  wire edge_seen = rise | fall;

  // sample stage then counter stage, one clock apart
  wire [3:0] filt_up = (filt_reg == vbmi_pkg::FILT_MAX) ? filt_reg : filt_reg + 4'h1;
  wire [3:0] filt_dn = (filt_reg == vbmi_pkg::FILT_MIN) ? filt_reg : filt_reg - 4'h1;
  assign filt_next = samp_reg ? filt_up : filt_dn;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      samp_reg <= 1'b0;
      filt_reg <= 4'h0;
      filt_q_reg <= 1'b0;
      prev_filt_reg <= 1'b0;
    end else begin
      samp_reg <= raw_rx_input;
      filt_reg <= filt_next;
      if (filt_next == vbmi_pkg::FILT_MAX) filt_q_reg <= 1'b1;
      else if (filt_next == vbmi_pkg::FILT_MIN) filt_q_reg <= 1'b0;
      prev_filt_reg <= filt_q_reg;
    end
  end

  // ------------------------------------------------------------
  // symbol timer on filtered level
  // ------------------------------------------------------------
  logic [vbmi_pkg::CNT_W-1:0] run_reg;
  logic eod_seen_reg;
  logic eof_seen_reg;
  logic idle_reg;
  wire [vbmi_pkg::CNT_W-1:0] run_sat = (run_reg == {vbmi_pkg::CNT_W{1'b1}}) ? run_reg
                                       : run_reg + 16'h0001;
  wire passive_eod = ~filt_q_reg && run_reg == 16'(vbmi_pkg::C_EOD_MIN);
  wire passive_eof = ~filt_q_reg && run_reg == 16'(vbmi_pkg::C_EOF);
  wire passive_idle = ~filt_q_reg && run_reg == 16'(vbmi_pkg::C_IDLE);
  wire brk_now = filt_q_reg && run_reg == 16'(vbmi_pkg::C_BRK);

  // ------------------------------------------------------------
  // receive decode
  // ------------------------------------------------------------
  logic rx_act_reg;
  logic [7:0] rx_sh_reg;
  logic [2:0] rx_bit_reg;
  logic [7:0] rx_crc_reg;
  logic [7:0] rx_data_reg;
  logic fast_rx_enable;
  logic tx_eod_req_reg;
  logic [vbmi_pkg::ST_W-1:0] state_vector_reg;
  vbmi_pkg::vbmi_evt_t evt;
  // symbol ended at this edge: level that ended is prev_filt_reg
  wire ended_active = fall;
  wire len_long = run_reg >= 16'(vbmi_pkg::C_BIT_MID);
  wire len_valid = run_reg >= 16'(vbmi_pkg::C_BIT_MIN);
  wire is_sof = ended_active && run_reg >= 16'(vbmi_pkg::C_SOF_MIN) && run_reg < 16'(vbmi_pkg::C_BRK);
  wire is_brk_end = ended_active && run_reg >= 16'(vbmi_pkg::C_BRK);
  wire is_data = rx_act_reg && edge_seen && len_valid && run_reg < 16'(vbmi_pkg::C_SOF_MIN)
                 && !(rise && run_reg >= 16'(vbmi_pkg::C_EOD_MIN));
  // active long or passive short is zero
  wire rx_bit = ended_active ? ~len_long : len_long;
  wire bad_sym = rx_act_reg && edge_seen && !len_valid;
  wire [7:0] crc_upd = vbmi_pkg::vbmi_crc_bit(rx_crc_reg, rx_bit);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_reg <= '0;
      eod_seen_reg <= 1'b0;
      eof_seen_reg <= 1'b0;
      idle_reg <= 1'b0;
      rx_act_reg <= 1'b0;
      rx_sh_reg <= 8'h00;
      rx_bit_reg <= 3'h0;
      rx_crc_reg <= vbmi_pkg::CRC_PRESET;
      rx_data_reg <= 8'h00;
    end else begin
      run_reg <= edge_seen ? 16'h0001 : run_sat;
      if (edge_seen) idle_reg <= 1'b0;
      else if (passive_idle) idle_reg <= 1'b1;
      if (is_sof) begin
        rx_act_reg <= 1'b1;
        rx_bit_reg <= 3'h0;
        rx_crc_reg <= vbmi_pkg::CRC_PRESET;
        eod_seen_reg <= 1'b0;
        eof_seen_reg <= 1'b0;
      end else if (brk_now || bad_sym) begin
        rx_act_reg <= 1'b0;
      end else if (is_data) begin
        rx_sh_reg <= {rx_sh_reg[6:0], rx_bit};
        rx_bit_reg <= rx_bit_reg + 3'h1;
        rx_crc_reg <= crc_upd;
        if (rx_bit_reg == 3'h7) rx_data_reg <= {rx_sh_reg[6:0], rx_bit};
      end
      if (passive_eod) eod_seen_reg <= 1'b1;
      if (passive_eof) begin
        eof_seen_reg <= 1'b1;
        rx_act_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // transmit encode
  // ------------------------------------------------------------
  typedef enum logic [2:0] {TX_IDLE, TX_WAIT, TX_SOF, TX_BIT, TX_EOD} vbmi_tx_t;
  vbmi_tx_t tx_state_reg;
  logic [7:0] tx_buf_reg;
  logic tx_full_reg;
  logic [7:0] tx_sh_reg;
  logic [2:0] tx_bit_reg;
  logic tx_crc_phase_reg;
  logic [3:0] tx_cnt_reg;
  logic [7:0] tx_crc_reg;
  logic [vbmi_pkg::CNT_W-1:0] tx_tmr_reg;
  logic tx_lvl_reg;
  logic tx_err_evt;
  wire tx_bit = tx_sh_reg[7];
  // length from level and value
  wire [vbmi_pkg::CNT_W-1:0] tx_len = (tx_lvl_reg ^ tx_bit) ? 16'(vbmi_pkg::C_LONG)
                                                            : 16'(vbmi_pkg::C_SHORT);
  wire tx_done = tx_tmr_reg == 16'h0001;
  wire last_bit = tx_bit_reg == 3'h7;
  // next byte after this one: buffered data or the crc byte
  wire [7:0] crc_byte = ~vbmi_pkg::vbmi_crc_bit(tx_crc_reg, tx_bit);
  wire more_data = !tx_crc_phase_reg && tx_full_reg && !tx_eod_req_reg
                   && tx_cnt_reg < 4'(vbmi_pkg::MAX_BYTES - 2);
  wire next_msb = more_data ? tx_buf_reg[7] : crc_byte[7];
  wire wr_hit = psel && penable && pwrite;
  wire wr_tx = wr_hit && paddr == vbmi_pkg::ADDR_TXDATA;
  wire bus_free = idle_reg || (eof_seen_reg && ~filt_q_reg && run_reg >= 16'(vbmi_pkg::C_IDLE));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state_reg <= TX_IDLE;
      tx_buf_reg <= 8'h00;
      tx_full_reg <= 1'b0;
      tx_sh_reg <= 8'h00;
      tx_bit_reg <= 3'h0;
      tx_crc_phase_reg <= 1'b0;
      tx_cnt_reg <= 4'h0;
      tx_crc_reg <= vbmi_pkg::CRC_PRESET;
      tx_tmr_reg <= '0;
      tx_lvl_reg <= 1'b0;
      raw_tx_output <= 1'b0;
      tx_err_evt <= 1'b0;
    end else begin
      tx_err_evt <= 1'b0;
      if (wr_tx && !tx_full_reg) begin
        tx_buf_reg <= pwdata[7:0];
        tx_full_reg <= 1'b1;
      end
      if (tx_state_reg != TX_IDLE && tx_state_reg != TX_WAIT && brk_now) begin
        tx_state_reg <= TX_IDLE;
        raw_tx_output <= 1'b0;
        tx_err_evt <= 1'b1;
        tx_full_reg <= 1'b0;
      end else begin
        if (tx_tmr_reg != 16'h0000) tx_tmr_reg <= tx_tmr_reg - 16'h0001;
        unique case (tx_state_reg)
          TX_IDLE: if (tx_full_reg) tx_state_reg <= TX_WAIT;
          TX_WAIT: begin
            // early rising edge during separation restarts timing
            if (bus_free || (eof_seen_reg && rise)) begin
              tx_state_reg <= TX_SOF;
              raw_tx_output <= 1'b1;
              tx_tmr_reg <= rise ? 16'(vbmi_pkg::C_SOF - 1) : 16'(vbmi_pkg::C_SOF);
              tx_crc_reg <= vbmi_pkg::CRC_PRESET;
              tx_cnt_reg <= 4'h0;
            end
          end
          TX_SOF: if (tx_done) begin
            tx_sh_reg <= tx_buf_reg;
            tx_full_reg <= 1'b0;
            tx_crc_phase_reg <= 1'b0;
            tx_bit_reg <= 3'h0;
            tx_lvl_reg <= 1'b0;
            raw_tx_output <= 1'b0;
            tx_state_reg <= TX_BIT;
            tx_tmr_reg <= tx_buf_reg[7] ? 16'(vbmi_pkg::C_LONG) : 16'(vbmi_pkg::C_SHORT);
          end
          TX_BIT: if (tx_done) begin
            if (!tx_crc_phase_reg) tx_crc_reg <= vbmi_pkg::vbmi_crc_bit(tx_crc_reg, tx_bit);
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
            tx_bit_reg <= tx_bit_reg + 3'h1;
            if (last_bit) begin
              if (!tx_crc_phase_reg) tx_cnt_reg <= tx_cnt_reg + 4'h1;
              if (more_data) begin
                tx_sh_reg <= tx_buf_reg;
                tx_full_reg <= 1'b0;
              end else if (!tx_crc_phase_reg) begin
                tx_sh_reg <= crc_byte;
                tx_crc_phase_reg <= 1'b1;
              end else begin
                tx_state_reg <= TX_EOD;
              end
            end
            tx_lvl_reg <= ~tx_lvl_reg;
            raw_tx_output <= ~tx_lvl_reg;
          end
          TX_EOD: begin
            raw_tx_output <= 1'b0;
            tx_state_reg <= TX_IDLE;
          end
          default: tx_state_reg <= TX_IDLE;
        endcase
        // reload bit timer on each new bit, level already toggled
        if (tx_state_reg == TX_BIT && tx_done && !(last_bit && tx_crc_phase_reg)) begin
          tx_tmr_reg <= ((~tx_lvl_reg) ^ (last_bit ? 1'b0 : tx_sh_reg[6]))
                        ? 16'(vbmi_pkg::C_LONG) : 16'(vbmi_pkg::C_SHORT);
          // first bit of a byte is passive, its length follows its value
          if (last_bit) begin
            tx_tmr_reg <= next_msb ? 16'(vbmi_pkg::C_LONG) : 16'(vbmi_pkg::C_SHORT);
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // apb slave and status
  // ------------------------------------------------------------
  wire wr_ctl = wr_hit && paddr == vbmi_pkg::ADDR_CTRL;
  wire wr_st = wr_hit && paddr == vbmi_pkg::ADDR_STATUS;
  wire rx_byte_done = is_data && rx_bit_reg == 3'h7;
  wire rx_crc_bad = rx_act_reg && passive_eod && rx_crc_reg != vbmi_pkg::CRC_GOOD;
  wire mapped = paddr == vbmi_pkg::ADDR_CTRL || paddr == vbmi_pkg::ADDR_STATUS
                || paddr == vbmi_pkg::ADDR_TXDATA || paddr == vbmi_pkg::ADDR_RXDATA;
  wire rx_brk = brk_now && rx_act_reg;
  logic [31:0] rd_mux;
  assign evt = '{rx_byte: rx_byte_done, crc_err: rx_crc_bad, inv_sym: rx_brk || bad_sym,
                 eof: passive_eof, tx_err: tx_err_evt};
  assign rd_mux = (paddr == vbmi_pkg::ADDR_CTRL) ? {30'h0, tx_eod_req_reg, fast_rx_enable} :
                  (paddr == vbmi_pkg::ADDR_STATUS) ? {24'h0, ~tx_full_reg,
                    tx_state_reg != TX_IDLE, idle_reg, state_vector_reg[4:0]} :
                  (paddr == vbmi_pkg::ADDR_TXDATA) ? {24'h0, tx_buf_reg} :
                  (paddr == vbmi_pkg::ADDR_RXDATA) ? {24'h0, rx_data_reg} : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_rx_enable <= 1'b0;
      tx_eod_req_reg <= 1'b0;
      state_vector_reg <= '0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      rx_filtered_o <= 1'b0;
    end else begin
      rx_filtered_o <= filt_q_reg;
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable) prdata <= rd_mux;
      if (wr_ctl) begin
        fast_rx_enable <= pwdata[vbmi_pkg::CTL_FAST_RX];
        tx_eod_req_reg <= pwdata[vbmi_pkg::CTL_TX_EOD];
      end
      if (rx_brk && fast_rx_enable) fast_rx_enable <= 1'b0;
      if (tx_state_reg == TX_EOD) tx_eod_req_reg <= 1'b0;
      // write one clears, a same-cycle event wins
      state_vector_reg[4:0] <= (state_vector_reg[4:0] & ~(wr_st ? pwdata[4:0] : 5'h00))
                               | {evt.tx_err, evt.eof, evt.inv_sym, evt.crc_err, evt.rx_byte};
      state_vector_reg[7:5] <= 3'h0;
    end
  end
endmodule // vbmi_top

// ==== bench/vbmi_xcvr_model.sv ====
/*
  transceiver model: wired-or of our driver and another node, a loop
  delay of DLY clocks, and noise flips on the receive pin.
  assumes the bench drives other_i and noise_i just after rising edges.
*/
module vbmi_xcvr_model #(
  parameter int DLY = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tx_i,
  input wire logic other_i,
  input wire logic noise_i,
  output logic rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DLY-1:0] pipe_reg;
  // active level dominates the line
  wire logic bus_level = tx_i | other_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pipe_reg <= '0;
    end else begin
      pipe_reg <= {pipe_reg[DLY-2:0], bus_level};
    end
  end
  assign rx_o = pipe_reg[DLY-1] ^ noise_i;
endmodule // vbmi_xcvr_model

// ==== bench/vbmi_top_monitor.sv ====
/*
  checker for vbmi_top: filter timing, apb answers, transmit limits.
  assumes it is bound to vbmi_top and sees that module's ports only.
*/
module vbmi_top_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic raw_rx_input,
  input wire logic raw_tx_output,
  input wire logic rx_filtered_o
);
  // ------------------------------------------------------------
  // run length counters
  // ------------------------------------------------------------
  function automatic logic [16:0] vbmi_run(input logic on, input logic [16:0] v);
    return !on ? 17'h0 : (&v) ? v : v + 17'h1;
  endfunction
  logic [16:0] hi_reg, lo_reg, txhi_reg, txlo_reg, pas_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {hi_reg, lo_reg, txhi_reg, txlo_reg, pas_reg} <= '0;
    end else begin
      hi_reg <= vbmi_run(raw_rx_input, hi_reg);
      lo_reg <= vbmi_run(!raw_rx_input, lo_reg);
      txhi_reg <= vbmi_run(raw_tx_output, txhi_reg);
      txlo_reg <= vbmi_run(!raw_tx_output, txlo_reg);
      pas_reg <= vbmi_run(!rx_filtered_o, pas_reg);
    end
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  filt_rise_late_a: assert property (hi_reg == 17'h12 |-> rx_filtered_o)
    else $error("filtered level still low");
  filt_fall_late_a: assert property (lo_reg == 17'h12 |-> !rx_filtered_o)
    else $error("filtered level still high");
  filt_rise_early_a: assert property ($rose(raw_rx_input) && lo_reg >= 17'h11
    |-> !rx_filtered_o [*8] ##1 !rx_filtered_o [*6]) else $error("filtered rose too soon");
  filt_fall_early_a: assert property ($fell(raw_rx_input) && hi_reg >= 17'h11
    |-> rx_filtered_o [*8] ##1 rx_filtered_o [*6]) else $error("filtered fell too soon");
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer in access cycle");
  apb_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  apb_err_a: assert property (psel && penable |-> pslverr == !(paddr == vbmi_pkg::ADDR_CTRL
    || paddr == vbmi_pkg::ADDR_STATUS || paddr == vbmi_pkg::ADDR_TXDATA
    || paddr == vbmi_pkg::ADDR_RXDATA))
    else $error("error answer wrong");
  apb_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  tx_no_break_a: assert property (txhi_reg < vbmi_pkg::C_BRK)
    else $error("active drive as long as a break");
  tx_start_idle_a: assert property ($rose(raw_tx_output) && txlo_reg >= vbmi_pkg::C_EOD
    |-> pas_reg >= vbmi_pkg::C_EOF || rx_filtered_o) else $error("frame start on busy bus");
  filt_rise_c: cover property ($rose(rx_filtered_o));
  tx_start_c: cover property ($rose(raw_tx_output));
  apb_err_c: cover property (pready && pslverr);
endmodule // vbmi_top_monitor

bind vbmi_top vbmi_top_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .raw_rx_input(raw_rx_input),
  .raw_tx_output(raw_tx_output), .rx_filtered_o(rx_filtered_o));

// ==== bench/tb_top.sv ====
/*
  testbench for vbmi_top: apb master tasks, transceiver model, noise.
  assumes the package vbmi_pkg and the checker bound to vbmi_top.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DLY = 2;
  logic clk_i, rst_i, psel, penable, pwrite, pready, pslverr, err;
  logic raw_rx_input, raw_tx_output, rx_filtered_o, other, noise;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int fail_count, check_count, n, w;

  vbmi_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .raw_rx_input(raw_rx_input), .raw_tx_output(raw_tx_output),
    .rx_filtered_o(rx_filtered_o));
  vbmi_xcvr_model #(.DLY(DLY)) i_xcvr (.clk_i(clk_i), .rst_i(rst_i),
    .tx_i(raw_tx_output), .other_i(other), .noise_i(noise), .rx_o(raw_rx_input));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // ------------------------------------------------------------
  // report, compare, bus and wait tasks
  // ------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d failures %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic miss(input string what);
    fail_count++;
    $display("CHECK FAILED at %0t: %s", $time, what);
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miss(what);
    end
  endtask
  task automatic span(input int got, input int lo, input int hi, input string what);
    check_count++;
    if (got < lo || got > hi) begin
      miss($sformatf("%s: %0d cycles", what, got));
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      miss("bus answer missing");
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wait_pin(input logic tx, input logic lvl, input int lim);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((tx ? raw_tx_output : rx_filtered_o) !== lvl && n < lim);
    if ((tx ? raw_tx_output : rx_filtered_o) !== lvl) begin
      miss("level change missing");
      wrap_up();
    end
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {rst_i, psel, penable, pwrite, other, noise} = 6'h20;
    paddr = 8'h00;
    pwdata = 32'h0;
    fail_count = 0;
    check_count = 0;
    void'($urandom(32'hBD19));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    apb(1'b0, vbmi_pkg::ADDR_CTRL, 32'h0);
    cmp(rd, 32'h0, "control after reset");
    apb(1'b0, vbmi_pkg::ADDR_STATUS, 32'h0);
    cmp(rd & 32'h1F, 32'h0, "event flags after reset");
    apb(1'b1, vbmi_pkg::ADDR_CTRL, 32'h1);
    apb(1'b0, vbmi_pkg::ADDR_CTRL, 32'h0);
    cmp(rd & 32'h1, 32'h1, "fast receive enable");
    apb(1'b1, vbmi_pkg::ADDR_CTRL, 32'h0);
    w = 4 + $urandom % 60;
    apb(1'b0, 8'(w * 4), 32'h0);
    cmp({31'h0, err}, 32'h1, "unmapped error");
    cmp(rd, 32'h0, "unmapped data");
    for (int lvl = 0; lvl < 2; lvl++) begin
      for (int i = 0; i < 12; i++) begin
        w = (i == 0) ? 13 : 1 + $urandom % 13;
        noise <= 1'b1;
        repeat (w) @(posedge clk_i);
        noise <= 1'b0;
        cmp(rx_filtered_o, lvl[0], "noise reached output");
        repeat (20) @(posedge clk_i);
        cmp(rx_filtered_o, lvl[0], "noise changed level");
      end
      other <= !lvl[0];
      wait_pin(1'b0, !lvl[0], 40);
      span(n, DLY + 15, DLY + 18, "filter delay");
    end
    apb(1'b0, vbmi_pkg::ADDR_STATUS, 32'h0);
    cmp((rd >> vbmi_pkg::ST_IDLE) & 32'h1, 32'h0, "idle too early");
    repeat (vbmi_pkg::C_IDLE + 100) @(posedge clk_i);
    apb(1'b0, vbmi_pkg::ADDR_STATUS, 32'h0);
    cmp((rd >> vbmi_pkg::ST_IDLE) & 32'h1, 32'h1, "idle missing");
    apb(1'b1, vbmi_pkg::ADDR_TXDATA, 32'h5A);
    wait_pin(1'b1, 1'b1, 100);
    wait_pin(1'b1, 1'b0, vbmi_pkg::C_BRK);
    span(n, vbmi_pkg::C_SOF - 1, vbmi_pkg::C_SOF + 1, "start symbol");
    wait_pin(1'b1, 1'b1, vbmi_pkg::C_EOD);
    span(n, vbmi_pkg::C_SHORT - 1, vbmi_pkg::C_SHORT + 1, "passive zero");
    wait_pin(1'b1, 1'b0, vbmi_pkg::C_EOD);
    span(n, vbmi_pkg::C_SHORT - 1, vbmi_pkg::C_SHORT + 1, "active one");
    apb(1'b0, vbmi_pkg::ADDR_STATUS, 32'h0);
    cmp((rd >> vbmi_pkg::ST_TX_BUSY) & 32'h1, 32'h1, "busy while sending");
    wrap_up();
  end
endmodule // tb_top
